/* File: rtl/fmcs_regs.sv */
// APB register bank of the fan monitor configuration and status block.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Voltage low register shows core bits 3:2 and supply bits 5:4.
// - Temperature low register shows remote one, local, remote two low bits.
// - Reading a low register freezes it and its high bytes until read.
// - Base variant: bit 0 clear gives fan drive two, set gives alert.
// - Latching variant: bit 0 clear gives thermal latch, set fan drive.
// - Bit 1 enables thermal pin, with pin function field and direction bits.
// - Thermal input asserted with boost bit forces fans to full duty.
// - Bit 3 selects fast speed measurement, four times per second.
// - Bits 4 to 7 make speed sensing continuous per fan input.
// - Global lock set makes the configuration register ignore writes.
// - Status bits 7:1 read zero until assertion reaches two steps.
// - Status bit 0 sets on thermal assertion, clears on status read.
// - Past two steps status is the 8-bit count of 22.76 ms steps.
// - Count above limit sets timer flag; zero limit flags at assertion.
module fmcs_regs #(
  parameter int unsigned STEP_CYCLES = fmcs_pkg::STEP_CYCLES_D,
  parameter bit          LATCHING    = 1'b0
) (
  // Clock, reset and enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurement results
  input  wire logic [9:0]  core_voltage_channel_i,
  input  wire logic [9:0]  supply_voltage_i,
  input  wire logic [9:0]  remote_one_temp_i,
  input  wire logic [9:0]  local_temp_i,
  input  wire logic [9:0]  remote_two_temp_i,
  // Shared pin sources
  input  wire logic        fan_drive_two_i,
  input  wire logic        alert_req_i,
  input  wire logic        thermal_latch_req_i,
  input  wire logic        overtemp_i,
  // Thermal pin, active low
  input  wire logic        thermal_pin_n_i,
  output logic             thermal_pin_n_o,
  output logic             thermal_pin_n_oe,
  // Fan control outputs
  output logic             shared_pin_o,
  output logic             fan_boost_o,
  output logic             fast_speed_o,
  output logic      [3:0]  continuous_speed_sense_o,
  output logic             fan_four_or_timer_flag_o
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [31:0] rdata_r;
  logic        ready_r;
  logic        err_r;
  logic [7:0]  cfg_r;
  logic [7:0]  lock_r;
  logic [7:0]  pin_func_r;
  logic [7:0]  dir_r;
  logic [7:0]  limit_r;
  logic        int_flag_r;
  logic        flag_r;
  logic [7:0]  dur_r;
  logic [23:0] presc_r;
  logic        act_q_r;
  logic [4:0]  frz_r;
  logic [9:0]  snap_r [5];
  logic        shared_r;
  logic        tp_oe_r;
  logic        boost_r;
  logic        fast_r;
  logic [3:0]  cont_r;

  wire [7:0] idx      = paddr[9:2];
  wire       addr_ok  = (paddr[11:10] == fmcs_pkg::ADDR_TOP_PAD) &&
                        (paddr[1:0] == fmcs_pkg::ADDR_WORD_PAD);
  wire       sel_vlow = addr_ok && (idx == fmcs_pkg::IDX_VOLT_LOW);
  wire       sel_tlow = addr_ok && (idx == fmcs_pkg::IDX_TEMP_LOW);
  wire       sel_cfg  = addr_ok && (idx == fmcs_pkg::IDX_FAN_CFG);
  wire       sel_stat = addr_ok && (idx == fmcs_pkg::IDX_TMR_STAT);
  wire       sel_lim  = addr_ok && (idx == fmcs_pkg::IDX_TMR_LIMIT);
  wire       sel_lock = addr_ok && (idx == fmcs_pkg::IDX_LOCK);
  wire       sel_pinf = addr_ok && (idx == fmcs_pkg::IDX_PIN_FUNC);
  wire       sel_dir  = addr_ok && (idx == fmcs_pkg::IDX_DIR_CFG);
  wire       sel_int  = addr_ok && (idx == fmcs_pkg::IDX_INT_STAT);
  wire [7:0] hi_off   = idx - fmcs_pkg::IDX_HIGH_BASE;
  wire       sel_high = addr_ok && (idx >= fmcs_pkg::IDX_HIGH_BASE) &&
                        (hi_off < 8'(fmcs_pkg::NUM_CH));
  wire       mapped   = sel_vlow | sel_tlow | sel_cfg | sel_stat |
                        sel_lim | sel_lock | sel_pinf | sel_dir |
                        sel_int | sel_high;

  // One wait state: ready rises at the first access edge, and the
  // transfer completes at the edge where the master sees it high.
  wire acc_go  = ce && psel && penable && !ready_r;
  wire done    = ce && psel && penable && ready_r;
  wire wr_done = done && pwrite;
  wire rd_done = done && !pwrite;

  // ****************************************************************
  // Measurement snapshots and freeze
  // ****************************************************************
  logic [9:0] live [5];
  assign live[fmcs_pkg::CH_CORE_VOLT]  = core_voltage_channel_i;
  assign live[fmcs_pkg::CH_SUPPLY]     = supply_voltage_i;
  assign live[fmcs_pkg::CH_REMOTE_ONE] = remote_one_temp_i;
  assign live[fmcs_pkg::CH_LOCAL]      = local_temp_i;
  assign live[fmcs_pkg::CH_REMOTE_TWO] = remote_two_temp_i;

  wire rd_vlow = rd_done && sel_vlow;
  wire rd_tlow = rd_done && sel_tlow;
  wire rd_high = rd_done && sel_high;

  genvar ch;
  generate
    for (ch = 0; ch < fmcs_pkg::NUM_CH; ch++) begin : g_ch
      localparam bit IS_VOLT = (ch < fmcs_pkg::CH_REMOTE_ONE);
      wire frz_set = IS_VOLT ? rd_vlow : rd_tlow;
      wire frz_clr = rd_high && (hi_off == 8'(ch));
      wire frz_nxt = frz_set | (frz_r[ch] & ~frz_clr);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          frz_r[ch]  <= 1'b0;
          snap_r[ch] <= fmcs_pkg::RST_RES;
        end else if (ce) begin
          frz_r[ch] <= frz_nxt;
          if (!frz_r[ch] && !frz_set) begin
            snap_r[ch] <= live[ch];
          end
        end
      end
    end
  endgenerate

  wire [7:0] volt_low = {2'h0,
                         snap_r[fmcs_pkg::CH_SUPPLY][1:0],
                         snap_r[fmcs_pkg::CH_CORE_VOLT][1:0],
                         2'h0};
  wire [7:0] temp_low = {snap_r[fmcs_pkg::CH_REMOTE_TWO][1:0],
                         snap_r[fmcs_pkg::CH_LOCAL][1:0],
                         snap_r[fmcs_pkg::CH_REMOTE_ONE][1:0],
                         2'h0};
  wire [2:0] hi_ch    = hi_off[2:0];
  wire [7:0] high_val = snap_r[hi_ch][9:2];

  // ****************************************************************
  // Thermal input and assertion timer
  // ****************************************************************
  logic thermal_pin_n_s;
  fmcs_sync #(
    .W (1)
  ) u_thermal_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .async_i (thermal_pin_n_i),
    .sync_o  (thermal_pin_n_s)
  );

  wire func_en  = cfg_r[fmcs_pkg::CFG_THERMAL_PIN_EN] &&
                  (pin_func_r[1:0] == fmcs_pkg::THERMAL_PIN_FUNC);
  wire dir_out  = |dir_r[fmcs_pkg::DIR_MSB:fmcs_pkg::DIR_LSB];
  wire act      = func_en && !thermal_pin_n_s;
  wire act_rise = act && !act_q_r;
  wire rd_stat  = rd_done && sel_stat;
  wire rd_int   = rd_done && sel_int;
  localparam int unsigned PRESC_W = fmcs_pkg::PRESC_W;
  wire tick     = act && (presc_r == PRESC_W'(STEP_CYCLES - 1));

  wire [23:0] presc_nxt = (rd_stat || !act) ? '0 :
                          tick ? '0 : presc_r + 24'h000001;
  wire        dur_full  = (dur_r == fmcs_pkg::TMR_FULL);
  wire [7:0]  dur_nxt   = rd_stat ? fmcs_pkg::RST_BYTE :
                          (tick && !dur_full) ?
                          dur_r + fmcs_pkg::TMR_ONE : dur_r;
  wire        flag_nxt  = act_rise | (flag_r & ~rd_stat);
  wire        shown     = (dur_r >= fmcs_pkg::TMR_SHOW_MIN);
  wire [7:0]  stat_val  = shown ? dur_r :
                          {7'h00, flag_r};
  wire        over_lim  = act && (limit_r == fmcs_pkg::LIMIT_NOW) ?
                          act_rise : (dur_r > limit_r);
  wire        int_nxt   = over_lim | (int_flag_r & ~rd_int);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q_r    <= 1'b0;
      presc_r    <= '0;
      dur_r      <= fmcs_pkg::RST_BYTE;
      flag_r     <= 1'b0;
      int_flag_r <= 1'b0;
    end else if (ce) begin
      act_q_r    <= act;
      presc_r    <= presc_nxt;
      dur_r      <= dur_nxt;
      flag_r     <= flag_nxt;
      int_flag_r <= int_nxt;
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  wire locked  = lock_r[fmcs_pkg::LOCK_BIT];
  wire wr_cfg  = wr_done && sel_cfg && !locked;
  wire [7:0] wb = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r      <= fmcs_pkg::RST_BYTE;
      lock_r     <= fmcs_pkg::RST_BYTE;
      pin_func_r <= fmcs_pkg::RST_BYTE;
      dir_r      <= fmcs_pkg::RST_BYTE;
      limit_r    <= fmcs_pkg::RST_BYTE;
    end else if (ce && wr_done) begin
      if (wr_cfg) begin
        cfg_r <= wb;
      end
      if (sel_lock) begin
        lock_r <= lock_r | wb;
      end
      if (sel_pinf) begin
        pin_func_r <= wb;
      end
      if (sel_dir) begin
        dir_r <= wb;
      end
      if (sel_lim) begin
        limit_r <= wb;
      end
    end
  end

  // ****************************************************************
  // Read data and APB answer
  // ****************************************************************
  logic [7:0] rsel;
  always_comb begin
    rsel = fmcs_pkg::RST_BYTE;
    case (1'b1)
      sel_vlow: rsel = volt_low;
      sel_tlow: rsel = temp_low;
      sel_cfg:  rsel = cfg_r;
      sel_stat: rsel = stat_val;
      sel_lim:  rsel = limit_r;
      sel_lock: rsel = lock_r;
      sel_pinf: rsel = pin_func_r;
      sel_dir:  rsel = dir_r;
      sel_int:  rsel = {2'h0, int_flag_r, 5'h00};
      sel_high: rsel = high_val;
      default:  rsel = fmcs_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= fmcs_pkg::RST_WORD;
    end else if (ce) begin
      ready_r <= acc_go;
      err_r   <= acc_go && !mapped;
      if (acc_go && !pwrite) begin
        rdata_r <= {24'h000000, rsel};
      end
    end
  end

  // ****************************************************************
  // Pin and fan control outputs
  // ****************************************************************
  // The shared pin is registered so that a mode change never glitches
  // the fan drive mid-cycle.
  wire sh_base  = cfg_r[fmcs_pkg::CFG_ALERT] ? !alert_req_i
                                             : fan_drive_two_i;
  wire sh_latch = cfg_r[fmcs_pkg::CFG_ALERT] ? fan_drive_two_i
                                             : thermal_latch_req_i;
  wire sh_nxt   = LATCHING ? sh_latch : sh_base;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_r <= 1'b0;
      tp_oe_r  <= 1'b0;
      boost_r  <= 1'b0;
      fast_r   <= 1'b0;
      cont_r   <= '0;
    end else if (ce) begin
      shared_r <= sh_nxt;
      tp_oe_r  <= func_en && dir_out && overtemp_i;
      boost_r  <= act && cfg_r[fmcs_pkg::CFG_BOOST];
      fast_r   <= cfg_r[fmcs_pkg::CFG_FAST];
      cont_r   <= cfg_r[fmcs_pkg::CFG_DC_MSB:fmcs_pkg::CFG_DC_LSB];
    end
  end

  assign prdata                   = rdata_r;
  assign pready                   = ready_r;
  assign pslverr                  = err_r;
  assign shared_pin_o             = shared_r;
  assign thermal_pin_n_o          = 1'b0;
  assign thermal_pin_n_oe         = tp_oe_r;
  assign fan_boost_o              = boost_r;
  assign fast_speed_o             = fast_r;
  assign continuous_speed_sense_o = cont_r;
  assign fan_four_or_timer_flag_o = int_flag_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    ce && psel && !penable && !ready_r;
  endsequence

  sequence s_access;
    ce && psel && penable;
  endsequence

  a_apb_one_wait: assert property (
    s_setup ##1 s_access |=> pready)
    else $error("APB access did not answer after one wait state.");

  a_lock_blocks_cfg: assert property (
    ce && locked |=> $stable(cfg_r))
    else $error("Configuration changed while locked.");

  a_freeze_holds_snap: assert property (
    ce && frz_r[fmcs_pkg::CH_CORE_VOLT] && !rd_high
    |=> $stable(snap_r[fmcs_pkg::CH_CORE_VOLT]))
    else $error("Frozen result changed before its high byte read.");

  a_flag_on_assert: assert property (
    ce && act_rise |=> flag_r)
    else $error("Assertion flag not set on thermal assertion.");

  a_flag_read_clear: assert property (
    ce && rd_stat && !act_rise |=> !flag_r)
    else $error("Assertion flag not cleared by status read.");

  a_tmr_hidden: assert property (
    dur_r < fmcs_pkg::TMR_SHOW_MIN |-> stat_val[7:1] == 7'h00)
    else $error("Duration bits visible before two steps.");

  a_dur_saturate: assert property (
    ce && dur_full && !rd_stat |=> dur_full)
    else $error("Duration count wrapped past full scale.");

  a_dur_on_tick: assert property (
    ce && !tick && !rd_stat |=> $stable(dur_r))
    else $error("Duration count moved without a step tick.");

  a_limit_zero: assert property (
    ce && act_rise && limit_r == fmcs_pkg::LIMIT_NOW
    |=> fan_four_or_timer_flag_o)
    else $error("Zero limit did not flag at assertion.");

  a_boost_follow: assert property (
    ce && act && cfg_r[fmcs_pkg::CFG_BOOST] |=> fan_boost_o)
    else $error("Boost not driven during thermal assertion.");

endmodule
`default_nettype wire

/* File: rtl/fmcs_pkg.sv */
// Constants shared by the fan monitor configuration and status registers.
package fmcs_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_VOLT_LOW   = 8'h76;
  localparam logic [7:0] IDX_TEMP_LOW   = 8'h77;
  localparam logic [7:0] IDX_FAN_CFG    = 8'h78;
  localparam logic [7:0] IDX_TMR_STAT   = 8'h79;
  localparam logic [7:0] IDX_TMR_LIMIT  = 8'h7A;
  localparam logic [7:0] IDX_LOCK       = 8'h90;
  localparam logic [7:0] IDX_PIN_FUNC   = 8'h91;
  localparam logic [7:0] IDX_DIR_CFG    = 8'h92;
  localparam logic [7:0] IDX_INT_STAT   = 8'h93;
  localparam logic [7:0] IDX_HIGH_BASE  = 8'hA0;
  localparam logic [1:0] ADDR_WORD_PAD  = 2'h0;
  localparam logic [1:0] ADDR_TOP_PAD   = 2'h0;

  // ****************************************************************
  // Measurement channels and field positions.
  // ****************************************************************
  localparam int unsigned NUM_CH        = 5;
  localparam int unsigned CH_CORE_VOLT  = 0;
  localparam int unsigned CH_SUPPLY     = 1;
  localparam int unsigned CH_REMOTE_ONE = 2;
  localparam int unsigned CH_LOCAL      = 3;
  localparam int unsigned CH_REMOTE_TWO = 4;
  localparam int unsigned RES_W         = 10;
  localparam int unsigned LOW_W         = 2;

  localparam int unsigned CFG_ALERT     = 0;
  localparam int unsigned CFG_THERMAL_PIN_EN  = 1;
  localparam int unsigned CFG_BOOST     = 2;
  localparam int unsigned CFG_FAST      = 3;
  localparam int unsigned CFG_DC_LSB    = 4;
  localparam int unsigned CFG_DC_MSB    = 7;
  localparam int unsigned LOCK_BIT      = 0;
  localparam int unsigned DIR_LSB       = 5;
  localparam int unsigned DIR_MSB       = 7;
  localparam int unsigned INT_TMR_BIT   = 5;
  localparam logic [1:0]  THERMAL_PIN_FUNC    = 2'h1;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [9:0]  RST_RES       = 10'h000;

  // ****************************************************************
  // Assertion timer.
  // ****************************************************************
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned STEP_TIME_US  = 22760;
  localparam int unsigned STEP_CYCLES_D = STEP_TIME_US * CLK_MHZ;
  localparam int unsigned PRESC_W       = 24;
  localparam logic [7:0]  TMR_SHOW_MIN  = 8'h02;
  localparam logic [7:0]  TMR_FULL      = 8'hFF;
  localparam logic [7:0]  TMR_ONE       = 8'h01;
  localparam logic [7:0]  LIMIT_NOW     = 8'h00;

endpackage

/* File: rtl/fmcs_sync.sv */
// Two-flop synchroniser for levels from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module fmcs_sync #(
  parameter int unsigned W = 1
) (
  // Clock, reset and enable
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else if (ce) begin
      stage1_r <= async_i;
      stage2_r <= stage1_r;
    end
  end

  assign sync_o = stage2_r;

endmodule
`default_nettype wire

/* File: bench/fmcs_host.sv */
// Host model: an APB master standing in for the management software.
`timescale 1ns/1ps
`default_nettype none
module fmcs_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer after some idle cycles, so the host is prompt or slow.
  // The request holds until pready is sampled high at a rising edge.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [1:0] idle,
                      output logic [31:0] rd, output logic err);
    repeat (idle) @(posedge pclk);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A released data bus shows a fresh pattern, not the last word.
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: bench/fmcs_regs_tb.sv */
// Self-checking bench of the fan monitor configuration and status registers.
`timescale 1ns/1ps
`default_nettype none
module fmcs_regs_tb;
  // ****************************************************************
  // Bench signals and instances
  // ****************************************************************
  logic pclk, presetn, ce, link_clk, thermal_pin_low, overtemp_i;
  logic fan_drive_two_i, alert_req_i, thermal_latch_req_i;
  logic [49:0] meas;
  logic [15:0] rnd;
  int err_total, n_checks;
  int cyc = 0;
  wire logic psel, penable, pwrite, pready, pslverr, shared2;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic thermal_pin_n_i, thermal_pin_n_o, thermal_pin_n_oe;
  wire logic shared_pin_o, fan_boost_o, fast_speed_o;
  wire logic fan_four_or_timer_flag_o;
  wire logic [3:0] continuous_speed_sense_o;
  wire logic [9:0] core_voltage_channel_i = meas[9:0];
  wire logic [9:0] supply_voltage_i = meas[19:10];
  wire logic [9:0] remote_one_temp_i = meas[29:20];
  wire logic [9:0] local_temp_i = meas[39:30];
  wire logic [9:0] remote_two_temp_i = meas[49:40];
  // Open-drain pin with a pull-up: either party may pull it low.
  assign thermal_pin_n_i = !(thermal_pin_low ||
                             (thermal_pin_n_oe && !thermal_pin_n_o));
  fmcs_host host (.*);
  fmcs_regs #(.STEP_CYCLES(8), .LATCHING(1'b0)) dut (.*);
  fmcs_regs #(.STEP_CYCLES(8), .LATCHING(1'b1)) dut2 (.*, .prdata(),
    .pready(), .pslverr(), .thermal_pin_n_o(), .thermal_pin_n_oe(),
    .shared_pin_o(shared2), .fan_boost_o(), .fast_speed_o(),
    .continuous_speed_sense_o(), .fan_four_or_timer_flag_o());
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // The 48 ns timebase of the thermal input has its own phase.
  initial begin
    link_clk = 1'b0;
    #3.1;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] low_exp(input logic [9:0] a, b, c);
    return {24'h0, c[1:0], b[1:0], a[1:0], 2'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    logic e;
    rnd = lfsr(rnd);
    host.xfer(w, a, d, rnd[1:0], r, e);
  endtask
  task automatic new_meas();
    @(posedge pclk);
    meas <= {rnd[1:0], lfsr(rnd), lfsr(~rnd), rnd};
    rnd = lfsr(lfsr(rnd));
    @(posedge pclk);
  endtask
  task automatic pulse(input int n, input logic boost);
    @(posedge link_clk);
    thermal_pin_low <= 1'b1;
    repeat (n) @(posedge link_clk);
    chk("boost", fan_boost_o, boost);
    thermal_pin_low <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic [49:0] old;
    logic [7:0] v;
    logic e, ex;
    int n, x;
    ce = 1'b1;
    presetn = 1'b0;
    thermal_pin_low = 1'b0;
    overtemp_i = 1'b0;
    fan_drive_two_i = 1'b0;
    alert_req_i = 1'b0;
    thermal_latch_req_i = 1'b0;
    meas = '0;
    rnd = 16'h0048;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 12'h1D8 + 12'(4 * i), 32'h0, r);
      chk("reset value", r, 32'h0);
    end
    // The low-bit reads above froze every channel; the high bytes free them.
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 12'h280 + 12'(4 * i), 32'h0, r);
      chk("reset high", r, 32'h0);
    end
    host.xfer(1'b0, 12'h300, 32'h0, 2'h0, r, e);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", r, 32'h0);
    $display("test reset and unmapped done");
    // Low bits first, then the high bytes, as the host must.
    for (int k = 0; k < 4; k++) begin
      new_meas();
      old = meas;
      bus(1'b0, 12'h1D8, 32'h0, r);
      chk("volt low", r, low_exp(old[9:0], old[19:10], 10'h0));
      bus(1'b0, 12'h1DC, 32'h0, r);
      chk("temp low", r, low_exp(old[29:20], old[39:30], old[49:40]));
      new_meas();
      for (int c = 0; c < 5; c++) begin
        bus(1'b0, 12'h280 + 12'(4 * c), 32'h0, r);
        chk("frozen high", r, {24'h0, old[10 * c + 2 +: 8]});
      end
      bus(1'b0, 12'h280, 32'h0, r);
      chk("released high", r, {24'h0, meas[9:2]});
    end
    $display("test low bits and freeze done");
    for (int k = 0; k < 6; k++) begin
      v = rnd[7:0];
      bus(1'b1, 12'h1E0, {24'h0, v}, r);
      bus(1'b0, 12'h1E0, 32'h0, r);
      chk("config readback", r, {24'h0, v});
      chk("fast speed", fast_speed_o, v[3]);
      chk("continuous", continuous_speed_sense_o, v[7:4]);
    end
    for (int k = 0; k < 8; k++) begin
      v = {7'h0, k[2]};
      bus(1'b1, 12'h1E0, {24'h0, v}, r);
      @(posedge pclk);
      fan_drive_two_i <= rnd[0];
      alert_req_i <= rnd[1];
      thermal_latch_req_i <= rnd[2];
      repeat (3) @(posedge pclk);
      ex = v[0] ? !alert_req_i : fan_drive_two_i;
      chk("base pin", shared_pin_o, ex);
      ex = v[0] ? fan_drive_two_i : thermal_latch_req_i;
      chk("latching pin", shared2, ex);
    end
    $display("test configuration done");
    bus(1'b1, 12'h244, 32'h1, r);
    bus(1'b1, 12'h1E0, 32'h6, r);
    bus(1'b1, 12'h1E8, 32'h0, r);
    pulse(1, 1'b1);
    chk("limit zero flag", fan_four_or_timer_flag_o, 1'b1);
    chk("boost release", fan_boost_o, 1'b0);
    bus(1'b0, 12'h1E4, 32'h0, r);
    chk("assert flag", r, 32'h1);
    bus(1'b0, 12'h1E4, 32'h0, r);
    chk("flag cleared", r, 32'h0);
    bus(1'b0, 12'h24C, 32'h0, r);
    chk("timer interrupt", r[5], 1'b1);
    @(posedge pclk);
    chk("interrupt cleared", fan_four_or_timer_flag_o, 1'b0);
    bus(1'b1, 12'h1E0, 32'h2, r);
    bus(1'b1, 12'h1E8, 32'h5, r);
    // The count is only known to a step, as the input is asynchronous.
    for (int k = 0; k < 4; k++) begin
      n = (k == 0) ? 3 : (k == 1) ? 12 : 5 + int'(rnd[4:0]);
      x = n * 6 / 5;
      bus(1'b0, 12'h24C, 32'h0, r);
      pulse(n, 1'b0);
      if (k < 2) chk("limit flag", fan_four_or_timer_flag_o, k[0]);
      bus(1'b0, 12'h1E4, 32'h0, r);
      chk("duration", 32'(r >= x - 1 && r <= x + 1), 32'h1);
    end
    pulse(260, 1'b0);
    bus(1'b0, 12'h1E4, 32'h0, r);
    chk("saturated", r, 32'hFF);
    $display("test thermal timer done");
    bus(1'b1, 12'h244, 32'h0, r);
    pulse(3, 1'b0);
    bus(1'b0, 12'h1E4, 32'h0, r);
    chk("function off", r, 32'h0);
    bus(1'b1, 12'h244, 32'h1, r);
    bus(1'b1, 12'h248, 32'h20, r);
    @(posedge pclk);
    overtemp_i <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("pin drive", thermal_pin_n_oe, 1'b1);
    chk("pin level", thermal_pin_n_i, 1'b0);
    overtemp_i <= 1'b0;
    bus(1'b1, 12'h1E0, 32'h5A, r);
    bus(1'b1, 12'h240, 32'h1, r);
    bus(1'b1, 12'h1E0, 32'hA5, r);
    bus(1'b0, 12'h1E0, 32'h0, r);
    chk("locked config", r, 32'h5A);
    $display("test pin function and lock done");
    final_report();
  end
endmodule
`default_nettype wire
